// ### include/lfs_pkg.sv
// package for the lazy guarded-state switch trap: control flag positions, instruction
// classes, fault codes and the carriers between decode, trap logic and the state engine.
// assumes one core clock and a synchronous active-high reset.
package lfs_pkg;
    localparam int CTRL_W = 32;
    localparam int EM_BIT = 2;
    localparam int TS_BIT = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 32'h0000_0000;
    localparam int TASK_W = 8;
    localparam int STATE_WORDS = 8;
    localparam int WORD_W = 32;
    localparam int AREA_W = 3;
    localparam logic [AREA_W-1:0] AREA_LAST = 3'h7;

    typedef enum logic [2:0] {
        LFS_OP_OTHER = 3'b000,
        LFS_OP_FP = 3'b001,
        LFS_OP_VEC = 3'b010,
        LFS_OP_MOV_CTRL = 3'b011,
        LFS_OP_CLEAR_TS = 3'b100,
        LFS_OP_SAVE = 3'b101,
        LFS_OP_RESTORE = 3'b110,
        LFS_OP_TASK_SWITCH = 3'b111
    } lfs_op_type;

    typedef enum logic [1:0] {
        LFS_FAULT_NONE = 2'b00,
        LFS_FAULT_DEV_UNAVAIL = 2'b01,
        LFS_FAULT_INV_OPCODE = 2'b10
    } lfs_fault_type;

    typedef struct packed {
        logic valid;
        lfs_op_type op;
        logic privileged;
        logic [CTRL_W-1:0] data;
    } lfs_instr_type;

    typedef struct packed {
        logic valid;
        lfs_fault_type fault;
        logic retire;
    } lfs_result_type;

    typedef struct packed {
        logic req;
        logic store;
        logic [AREA_W-1:0] index;
        logic [WORD_W-1:0] wdata;
    } lfs_mem_type;
endpackage : lfs_pkg

// ### logic/lfs_state_mem.sv
// guarded register file: a small word memory holding the floating-point and vector state.
// assumes one port used by the trap unit; read data is registered.
module lfs_state_mem
    import lfs_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic rst, // synchronous reset
    input wire logic we, // write strobe
    input wire logic [AREA_W-1:0] addr, // word index
    input wire logic [WORD_W-1:0] wdata, // write word
    output logic [WORD_W-1:0] rdata // registered read word
);
    logic [WORD_W-1:0] mem [STATE_WORDS];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem[addr];
        end
    end
endmodule : lfs_state_mem

// ### logic/lfs_trap.sv
// Overview of operation
// RL1: while the switched flag is set, a decoded guarded-state instruction faults before it executes.
// RL2: with the switched flag at 1, any access to the guarded registers gives the unavailable fault, except a vector instruction with the emulation flag set.
// RL3: an instruction that does not use the guarded state never gives the unavailable fault.
// RL4: a native hardware task switch sets the switched flag.
// RL5: a privileged move to the control register sets or clears the switched flag as written.
// RL6: a dedicated instruction clears only the switched flag; the handler runs it before swapping.
// RL7: the full save and restore instructions move the whole guarded state to or from memory.
// RL8: the software switcher writes the flag as 1 for a non-owner task and 0 for the owner.
// RL9: software keeps one save area per task and a record of the state owner.
// RL10: the handler clears the flag, then saves, restores and records the owner, in that order.
// RL11: a guarded vector instruction with the emulation flag set gives the invalid-opcode fault.
// RL12: the unavailable fault is precise: the instruction has no effect and re-executes later.
// file holds the trap unit: control register, fault decision and full state transfer engine.
// assumes decode presents one instruction at a time and waits for a result before the next.
module lfs_trap
    import lfs_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire logic rst, // synchronous reset, active high
    input wire lfs_instr_type instr, // decoded instruction
    input wire logic [WORD_W-1:0] mem_rdata, // save image word from memory
    output lfs_result_type result, // retire or fault answer
    output logic [CTRL_W-1:0] system_control_reg, // control register value
    output lfs_mem_type mem_port, // save image access
    output logic busy // transfer in progress
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAVE = 2'b01,
        ST_RESTORE = 2'b10,
        ST_LAST = 2'b11
    } lfs_state_type;

    lfs_state_type state;
    logic [AREA_W-1:0] index;
    logic task_switched_flag;
    logic emulation_flag;
    logic guarded;
    logic exec_ok;
    logic idle;
    logic ld_pend;
    logic [AREA_W-1:0] ld_idx;
    logic rf_we;
    logic [AREA_W-1:0] rf_addr;
    logic [WORD_W-1:0] rf_rdata;
    lfs_fault_type fault;

    assign task_switched_flag = system_control_reg[TS_BIT];
    assign emulation_flag = system_control_reg[EM_BIT];
    // only these classes touch the guarded registers
    assign guarded = instr.op inside {LFS_OP_FP, LFS_OP_VEC, LFS_OP_SAVE, LFS_OP_RESTORE}; // see RL3

    always_comb begin
        if (instr.op == LFS_OP_VEC && emulation_flag) begin
            fault = LFS_FAULT_INV_OPCODE; // see RL11
        end else if (guarded && task_switched_flag) begin
            fault = LFS_FAULT_DEV_UNAVAIL; // see RL1 see RL2
        end else begin
            fault = LFS_FAULT_NONE;
        end
    end

    // the last restore word lands after the answer, so hold off a new op that cycle
    assign idle = state == ST_IDLE && !ld_pend;
    // a faulting instruction must not reach any state update
    assign exec_ok = instr.valid && idle && fault == LFS_FAULT_NONE; // see RL12

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            system_control_reg <= CTRL_RESET;
        end else if (exec_ok) begin
            unique case (instr.op)
                LFS_OP_TASK_SWITCH: system_control_reg[TS_BIT] <= 1'b1; // see RL4
                LFS_OP_CLEAR_TS: begin
                    if (instr.privileged) begin
                        system_control_reg[TS_BIT] <= 1'b0; // see RL6
                    end
                end
                LFS_OP_MOV_CTRL: begin
                    if (instr.privileged) begin
                        system_control_reg <= instr.data; // see RL5
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // full transfer walks every word; memory side issues one word per cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= ST_IDLE;
            index <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    index <= '0;
                    if (exec_ok && instr.op == LFS_OP_SAVE) begin
                        state <= ST_SAVE; // see RL7
                    end else if (exec_ok && instr.op == LFS_OP_RESTORE) begin
                        state <= ST_RESTORE; // see RL7
                    end
                end
                ST_SAVE, ST_RESTORE: begin
                    index <= index + 3'h1;
                    if (index == AREA_LAST) begin
                        state <= ST_LAST;
                    end
                end
                ST_LAST: state <= ST_IDLE;
            endcase
        end
    end

    // save reads one word ahead, since register file data is registered;
    // restore writes while the load answer stands, one cycle after the request
    assign rf_we = ld_pend; // see RL7
    assign rf_addr = ld_pend ? ld_idx : (state == ST_SAVE ? index + 3'h1 : 3'h0); // see RL7

    lfs_state_mem u_regs (
        .ref_clk(ref_clk),
        .rst(rst),
        .we(rf_we),
        .addr(rf_addr),
        .wdata(mem_rdata),
        .rdata(rf_rdata)
    );

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_port <= '0;
        end else begin
            mem_port.req <= state == ST_SAVE || state == ST_RESTORE;
            mem_port.store <= state == ST_SAVE;
            mem_port.index <= index; // see RL7
            mem_port.wdata <= state == ST_SAVE ? rf_rdata : '0; // see RL7
        end
    end

    // marks the cycle in which a load answer stands on mem_rdata
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ld_pend <= 1'b0;
            ld_idx <= '0;
        end else begin
            ld_pend <= mem_port.req && !mem_port.store; // see RL7
            ld_idx <= mem_port.index;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result <= '0;
        end else begin
            result.valid <= instr.valid && idle && !(exec_ok && instr.op inside {LFS_OP_SAVE,
                LFS_OP_RESTORE}) || state == ST_LAST;
            result.fault <= idle && instr.valid ? fault : LFS_FAULT_NONE;
            result.retire <= exec_ok && !(instr.op inside {LFS_OP_SAVE, LFS_OP_RESTORE}) || state == ST_LAST;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy <= 1'b0;
        end else begin
            busy <= state != ST_IDLE && state != ST_LAST || exec_ok && instr.op inside {LFS_OP_SAVE,
                LFS_OP_RESTORE};
        end
    end

    AST_FAULT_ON_TS: assert property (@(posedge ref_clk) disable iff (rst) // see RL1
        instr.valid && idle && task_switched_flag && instr.op == LFS_OP_FP
        |=> result.valid && result.fault == LFS_FAULT_DEV_UNAVAIL && !result.retire)
        else $error("guarded op with flag set did not fault");
    AST_VEC_FAULT: assert property (@(posedge ref_clk) disable iff (rst) // see RL2
        instr.valid && idle && task_switched_flag && !emulation_flag && instr.op == LFS_OP_VEC
        |=> result.fault == LFS_FAULT_DEV_UNAVAIL)
        else $error("vector access with flag set did not fault");
    AST_NO_SPURIOUS: assert property (@(posedge ref_clk) disable iff (rst) // see RL3
        instr.valid && idle && !guarded |=> result.fault != LFS_FAULT_DEV_UNAVAIL)
        else $error("unavailable fault on unguarded op");
    AST_HW_SWITCH: assert property (@(posedge ref_clk) disable iff (rst) // see RL4
        exec_ok && instr.op == LFS_OP_TASK_SWITCH |=> system_control_reg[TS_BIT])
        else $error("task switch left flag clear");
    AST_MOV_WRITE: assert property (@(posedge ref_clk) disable iff (rst) // see RL5
        exec_ok && instr.op == LFS_OP_MOV_CTRL && instr.privileged |=> system_control_reg == $past(instr.data))
        else $error("control move not stored");
    AST_UNPRIV_MOV: assert property (@(posedge ref_clk) disable iff (rst) // see RL5
        exec_ok && instr.op inside {LFS_OP_MOV_CTRL, LFS_OP_CLEAR_TS} && !instr.privileged
        |=> $stable(system_control_reg))
        else $error("unprivileged control write took effect");
    AST_CLEAR_ONLY: assert property (@(posedge ref_clk) disable iff (rst) // see RL6
        exec_ok && instr.op == LFS_OP_CLEAR_TS && instr.privileged
        |=> system_control_reg == ($past(system_control_reg) & ~(32'h1 << TS_BIT)))
        else $error("flag clear disturbed other bits");
    AST_FULL_XFER: assert property (@(posedge ref_clk) disable iff (rst) // see RL7
        exec_ok && instr.op == LFS_OP_SAVE |=> busy [*8] ##1 busy ##1 result.valid && result.retire)
        else $error("save did not take eight words");
    AST_SAVE_ORDER: assert property (@(posedge ref_clk) disable iff (rst) // see RL7
        state == ST_SAVE |=> mem_port.req && mem_port.store && mem_port.index == $past(index))
        else $error("save word out of order");
    AST_LOAD_ORDER: assert property (@(posedge ref_clk) disable iff (rst) // see RL7
        state == ST_RESTORE |=> mem_port.req && !mem_port.store && mem_port.index == $past(index))
        else $error("restore word out of order");
    AST_LOAD_LANDS: assert property (@(posedge ref_clk) disable iff (rst) // see RL7
        mem_port.req && !mem_port.store |=> rf_we && rf_addr == $past(mem_port.index))
        else $error("restore word not written back");
    AST_EMUL_UD: assert property (@(posedge ref_clk) disable iff (rst) // see RL11
        instr.valid && idle && emulation_flag && instr.op == LFS_OP_VEC
        |=> result.fault == LFS_FAULT_INV_OPCODE)
        else $error("vector op with emulation flag not invalid");
    AST_PRECISE: assert property (@(posedge ref_clk) disable iff (rst) // see RL12
        instr.valid && idle && fault != LFS_FAULT_NONE |=> $stable(system_control_reg) && !busy)
        else $error("faulting op changed state");

    COV_NM: cover property (@(posedge ref_clk) result.fault == LFS_FAULT_DEV_UNAVAIL);
    COV_UD: cover property (@(posedge ref_clk) result.fault == LFS_FAULT_INV_OPCODE);
    COV_SAVE: cover property (@(posedge ref_clk) state == ST_SAVE ##8 state == ST_LAST);
    COV_RESTORE: cover property (@(posedge ref_clk) state == ST_RESTORE ##8 state == ST_LAST);
endmodule : lfs_trap

// ### test/lfs_os_model.sv
// save area memory that the trap unit's save and restore engine talks to.
// assumes a load is answered the cycle after its request, never stalled.
module lfs_os_model
    import lfs_pkg::*;
(
    input wire logic ref_clk, // core clock
    input wire lfs_mem_type mem_port, // word transfer request
    input wire logic [1:0] area, // save area of the task in hand
    output logic [WORD_W-1:0] mem_rdata // load answer
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WORD_W-1:0] img [4][STATE_WORDS]; // one area per task
    logic [WORD_W-1:0] last = '0;
    logic ld = 1'b0;
    always @(posedge ref_clk) begin
        ld <= mem_port.req && !mem_port.store;
        if (mem_port.req && mem_port.store) begin
            img[area][mem_port.index] <= mem_port.wdata;
        end
        if (mem_port.req && !mem_port.store) begin
            last <= img[area][mem_port.index];
        end
    end
    // outside a load answer show the inverse, so a stale word never passes
    assign mem_rdata = ld ? last : ~last;
endmodule : lfs_os_model

// ### test/lazy_fp_state_switch_trap_tb.sv
// self-checking bench for the trap unit with a save area model on its memory side.
// assumes one op in flight; inputs move on the falling edge.
module lazy_fp_state_switch_trap_tb import lfs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] TS_M = 32'h1 << TS_BIT;
    localparam logic [31:0] EM_M = 32'h1 << EM_BIT;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    lfs_instr_type instr = '0;
    lfs_result_type result;
    lfs_mem_type mem_port;
    logic [31:0] scr, mem_rdata, seed = 32'h3d581fb8, d;
    logic [1:0] area = 2'h0, owner = 2'h0;
    logic [2:0] exp_idx = 3'h0;
    logic busy;
    int errors = 0, compares = 0, cyc = 0;
    lfs_op_type gops [4] = '{LFS_OP_FP, LFS_OP_VEC, LFS_OP_SAVE, LFS_OP_RESTORE};

    lfs_trap lfs_trap_i (.ref_clk(ref_clk), .rst(rst), .instr(instr), .mem_rdata(mem_rdata),
        .result(result), .system_control_reg(scr), .mem_port(mem_port), .busy(busy));
    lfs_os_model lfs_os_model_i (.ref_clk(ref_clk), .mem_port(mem_port), .area(area),
        .mem_rdata(mem_rdata));

    always #10 ref_clk = ~ref_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    // lat of 0 skips the latency figure
    task automatic do_op(input lfs_op_type op, input logic priv, input logic [31:0] data,
        input lfs_fault_type f, input int lat);
        int n;
        n = 0;
        @(negedge ref_clk);
        instr = '{1'b1, op, priv, data};
        do begin
            @(negedge ref_clk);
            n++;
            if (n == 1) check("busy", 32'(busy), 32'(lat > 1));
        end while (result.valid !== 1'b1 && n < 40);
        instr.valid = 1'b0;
        check("busy_end", 32'(busy), 32'h0);
        check("fault", 32'(result.fault), 32'(f));
        check("retire", 32'(result.retire), 32'(f == LFS_FAULT_NONE));
        if (lat > 0) check("latency", n, lat);
    endtask : do_op

    task automatic switch_to(input logic [1:0] t);
        d = (t != owner) ? TS_M : 32'h0;
        do_op(LFS_OP_MOV_CTRL, 1'b1, d, LFS_FAULT_NONE, 1);
    endtask : switch_to

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            errors++;
            close_out();
        end
        if (mem_port.req === 1'b1) begin
            check("index", 32'(mem_port.index), 32'(exp_idx));
            exp_idx <= exp_idx + 3'h1;
        end
    end

    initial begin
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        check("reset", scr, CTRL_RESET);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            d = seed & ~EM_M;
            do_op(LFS_OP_MOV_CTRL, 1'b1, d, LFS_FAULT_NONE, 1);
            check("ctrl", scr, d);
            do_op(LFS_OP_MOV_CTRL, 1'b0, ~d, LFS_FAULT_NONE, 1);
            check("ctrl_unpriv", scr, d);
            do_op(LFS_OP_CLEAR_TS, 1'b1, ~seed, LFS_FAULT_NONE, 1);
            check("clear", scr, d & ~TS_M);
        end
        $display("test control done");
        do_op(LFS_OP_MOV_CTRL, 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        foreach (gops[i]) if (i < 2) do_op(gops[i], 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        do_op(LFS_OP_TASK_SWITCH, 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        check("switch", scr, TS_M);
        switch_to(2'h1);
        check("flag_set", scr, TS_M);
        foreach (gops[i]) begin
            do_op(gops[i], 1'b1, 32'h0, LFS_FAULT_DEV_UNAVAIL, 1);
            check("no_effect", scr, TS_M);
        end
        do_op(LFS_OP_OTHER, 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        $display("test trap done");
        for (int i = 0; i < STATE_WORDS; i++) begin
            seed = lfsr(seed);
            lfs_os_model_i.img[1][i] = seed;
        end
        // guarded transfers fault with the flag up, so it drops before the swap
        do_op(LFS_OP_CLEAR_TS, 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        area = owner;
        do_op(LFS_OP_SAVE, 1'b1, 32'h0, LFS_FAULT_NONE, 10);
        area = 2'h1;
        do_op(LFS_OP_RESTORE, 1'b1, 32'h0, LFS_FAULT_NONE, 10);
        owner = 2'h1;
        switch_to(2'h1);
        do_op(LFS_OP_FP, 1'b1, 32'h0, LFS_FAULT_NONE, 1);
        area = 2'h2;
        do_op(LFS_OP_SAVE, 1'b1, 32'h0, LFS_FAULT_NONE, 10);
        for (int i = 0; i < STATE_WORDS; i++) begin
            check("image", lfs_os_model_i.img[2][i], lfs_os_model_i.img[1][i]);
        end
        $display("test handler done");
        do_op(LFS_OP_MOV_CTRL, 1'b1, EM_M, LFS_FAULT_NONE, 1);
        do_op(LFS_OP_VEC, 1'b1, 32'h0, LFS_FAULT_INV_OPCODE, 1);
        do_op(LFS_OP_MOV_CTRL, 1'b1, EM_M | TS_M, LFS_FAULT_NONE, 1);
        do_op(LFS_OP_VEC, 1'b1, 32'h0, LFS_FAULT_INV_OPCODE, 1);
        $display("test emulation done");
        close_out();
    end
endmodule : lazy_fp_state_switch_trap_tb
